// ===== hdl/pdh_core.sv
// pin power-down hold: with the sleep option on, freezes pins and logic while the sleep pin is high
`timescale 1ns/1ps
module pdh_core (
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_i,
   input  wire logic                     sleep_option_i,
   input  wire logic                     sleep_request_pin_i,
   input  wire logic [pdh_pkg::PIN_W-1:0] pin_in_i,
   input  wire logic [pdh_pkg::PIN_W-1:0] logic_data_i,
   input  wire logic [pdh_pkg::PIN_W-1:0] logic_oe_i,
   output logic      [pdh_pkg::PIN_W-1:0] array_in_o,
   output logic                          array_sleep_pin_o,
   output logic                          logic_run_o,
   output logic      [pdh_pkg::PIN_W-1:0] pin_out_o,
   output logic      [pdh_pkg::PIN_W-1:0] pin_oe_o,
   output logic      [pdh_pkg::PIN_W-1:0] keeper_on_o,
   output logic                          asleep_o,
   output logic                          wake_busy_o
);
   localparam int unsigned W = pdh_pkg::PIN_W;

   logic         sleep_pin_s;
   logic [W-1:0] pin_in_s;

   // the sleep pin goes through the same filter as data pins
   pdh_sync #(.W(W + 1)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .d_i       ({sleep_request_pin_i, pin_in_i}),
      .q_o       ({sleep_pin_s, pin_in_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // sleep sequencer

   pdh_pkg::pdh_state_e            state, next_state;
   logic [pdh_pkg::WAKE_CNT_W-1:0] wake_cnt, next_wake_cnt;
   logic                         sleep_req;

   // with the option off the pin is an ordinary input
   assign sleep_req = sleep_option_i & sleep_pin_s;

   always_comb begin
      next_state    = state;
      next_wake_cnt = wake_cnt;
      case (state)
         pdh_pkg::PDH_RUN: begin
            if (sleep_req) begin
               next_state = pdh_pkg::PDH_SLEEP;
            end
         end
         pdh_pkg::PDH_SLEEP: begin
            if (!sleep_req) begin
               next_state    = pdh_pkg::PDH_WAKE;
               // the window is shortened by the filter delay and two state stages so that the
               // whole path from pin low to running fits in 1 us
               next_wake_cnt = pdh_pkg::WAKE_CNT_W'(pdh_pkg::WAKE_LOAD);
            end
         end
         pdh_pkg::PDH_WAKE: begin
            // a fresh request during wake-up sleeps again at once
            if (sleep_req) begin
               next_state = pdh_pkg::PDH_SLEEP;
            end else if (wake_cnt == '0) begin
               next_state = pdh_pkg::PDH_RUN;
            end else begin
               next_wake_cnt = wake_cnt - 1'b1;
            end
         end
         default: next_state = pdh_pkg::PDH_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state    <= pdh_pkg::PDH_RUN;
         wake_cnt <= '0;
      end else begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // capture only while running and no filtered request is pending
   function automatic logic may_capture(
      input pdh_pkg::pdh_state_e st,
      input logic                req
   );
      return (st == pdh_pkg::PDH_RUN) && !req;
   endfunction

   // one vector either takes its fresh value or keeps what it holds
   function automatic logic [W-1:0] hold_or_take(
      input logic         take,
      input logic [W-1:0] fresh,
      input logic [W-1:0] held
   );
      logic [W-1:0] res;
      res = held;
      if (take) begin
         res = fresh;
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // status flags

   logic         run, next_run;
   logic         asleep, next_asleep;
   logic         busy, next_busy;

   always_comb begin
      next_run    = (next_state == pdh_pkg::PDH_RUN);
      next_asleep = (next_state == pdh_pkg::PDH_SLEEP);
      next_busy   = (next_state == pdh_pkg::PDH_WAKE);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         run    <= 1'b1;
         asleep <= 1'b0;
         busy   <= 1'b0;
      end else begin
         run    <= next_run;
         asleep <= next_asleep;
         busy   <= next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin hold and output freeze

   logic         take;
   logic [W-1:0] array_in, next_array_in;
   logic [W-1:0] pin_out, next_pin_out;
   logic [W-1:0] pin_oe, next_pin_oe;

   // capture stops the cycle the filtered request is seen, so array_in holds what stood before the pin rose,
   // while pin_out and pin_oe hold the unfiltered values of the cycle before that; wake resumes from them
   assign take = may_capture(state, sleep_req);

   always_comb begin
      next_array_in = hold_or_take(take, pin_in_s, array_in);
      next_pin_out  = hold_or_take(take, logic_data_i, pin_out);
      next_pin_oe   = hold_or_take(take, logic_oe_i, pin_oe);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         array_in <= pdh_pkg::DATA_RST;
         pin_out  <= pdh_pkg::DATA_RST;
         pin_oe   <= pdh_pkg::OE_RST;
      end else begin
         array_in <= next_array_in;
         pin_out  <= next_pin_out;
         pin_oe   <= next_pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sleep pin as array input

   logic         arr_sp, next_arr_sp;

   always_comb begin
      // pin reaches the array only without the option
      next_arr_sp = 1'b0;
      if (!sleep_option_i) begin
         next_arr_sp = sleep_pin_s;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         arr_sp <= 1'b0;
      end else begin
         arr_sp <= next_arr_sp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin keepers

   logic [W-1:0] keeper, next_keeper;

   always_comb begin
      // forced on only while asleep; awake the pin cells run them from
      // their own option outside this block
      next_keeper = {W{next_state == pdh_pkg::PDH_SLEEP}};
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         keeper <= '0;
      end else begin
         keeper <= next_keeper;
      end
   end

   assign array_in_o        = array_in;
   assign array_sleep_pin_o = arr_sp;
   assign logic_run_o       = run;
   assign pin_out_o         = pin_out;
   assign pin_oe_o          = pin_oe;
   assign keeper_on_o       = keeper;
   assign asleep_o          = asleep;
   assign wake_busy_o       = busy;
endmodule

// ===== hdl/pdh_pkg.sv
// constants and types for the pin power-down hold block
package pdh_pkg;
   localparam int unsigned PIN_W        = 8;
   localparam int unsigned CLK_HZ       = 25_000_000;
   // time from sleep pin low until inputs, enables and outputs are valid
   localparam int unsigned WAKE_NS      = 1000;
   localparam int unsigned WAKE_CYC     = (WAKE_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned WAKE_CNT_W   = 6;
   // filter stages between the sleep pin and the sequencer
   localparam int unsigned SYNC_CYC     = 4;
   // wake counter load: filter and state stages eat into the window
   localparam int unsigned WAKE_LOAD    = WAKE_CYC - SYNC_CYC - 2;
   // least time inputs must stand before the sleep pin rises (far side)
   localparam int unsigned SETUP_NS     = 7;
   localparam logic [PIN_W-1:0] DATA_RST = 8'h00;
   localparam logic [PIN_W-1:0] OE_RST   = 8'h00;

   typedef enum logic [1:0] {
      PDH_RUN   = 2'b00,
      PDH_SLEEP = 2'b01,
      PDH_WAKE  = 2'b10
   } pdh_state_e;
endpackage

// ===== hdl/pdh_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pdh_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1, s2, s3, q;
   logic [W-1:0] next_q;

   always_comb begin
      next_q = q;
      for (int i = 0; i < W; i++) begin
         if (s2[i] == s3[i]) begin
            next_q[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end

   assign q_o = q;
endmodule

// ===== verif/pdh_core_tb.sv
// self-checking bench for the sleep hold block
`timescale 1ns/1ps
module pdh_core_tb;
   logic       clk_sys_i, rst_i, sleep_option_i, sleep_request_pin_i;
   logic [7:0] pin_in_i, logic_data_i, logic_oe_i, array_in_o, pin_out_o;
   logic [7:0] pin_oe_o, keeper_on_o, h_out, h_oe, h_arr;
   logic       array_sleep_pin_o, logic_run_o, asleep_o, wake_busy_o;
   logic       sleep_cmd;
   int         num_errors, tests_run;
   pdh_core DUT (.*);
   pdh_far_side FAR (.clk_sys_i, .sleep_cmd_i(sleep_cmd),
      .sleep_pin_o(sleep_request_pin_i), .pin_o(pin_in_i),
      .data_o(logic_data_i), .oe_o(logic_oe_i));
   initial begin
      clk_sys_i = 0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [7:0] exp_keep(input logic sleeping);
      return sleeping ? 8'hFF : 8'h00;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic nap(input int len);
      @(posedge clk_sys_i) sleep_cmd <= 1;
      repeat (10) @(negedge clk_sys_i);
      check({5'h00, asleep_o, array_sleep_pin_o, logic_run_o}, 8'h04);
      check(keeper_on_o, exp_keep(1'b1));
      {h_out, h_oe, h_arr} = {pin_out_o, pin_oe_o, array_in_o};
      repeat (len) @(negedge clk_sys_i);
      check(pin_out_o, h_out);
      check(pin_oe_o, h_oe);
      check(array_in_o, h_arr);
      @(posedge clk_sys_i) sleep_cmd <= 0;
      // sync and state stages before the busy check, then the rest of the wake window
      repeat (10) @(negedge clk_sys_i);
      check({6'h00, asleep_o, wake_busy_o}, 8'h01);
      repeat (17) @(negedge clk_sys_i);
      check({7'h00, logic_run_o}, 8'h01);
      check(pin_out_o, h_out);
   endtask
   initial begin
      void'($urandom(83884));
      rst_i = 1;
      sleep_option_i = 0;
      sleep_cmd = 0;
      num_errors = 0;
      tests_run = 0;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 0;
      @(posedge clk_sys_i) sleep_cmd <= 1;
      repeat (10) @(negedge clk_sys_i);
      check({6'h00, asleep_o, array_sleep_pin_o}, 8'h01);
      @(posedge clk_sys_i) rst_i <= 1;
      sleep_cmd <= 0;
      sleep_option_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 0;
      for (int k = 0; k < 6; k++) nap(1 + $urandom_range(40));
      wrap_up();
   end
   initial begin
      repeat (2000) @(posedge clk_sys_i);
      num_errors++;
      wrap_up();
   end
endmodule

// ===== verif/pdh_far_side.sv
// far-side model: random pins, user data and sleep pin
`timescale 1ns/1ps
module pdh_far_side (
   input  wire logic       clk_sys_i,
   input  wire logic       sleep_cmd_i,
   output logic            sleep_pin_o,
   output logic [7:0]      pin_o,
   output logic [7:0]      data_o,
   output logic [7:0]      oe_o
);
   initial {sleep_pin_o, pin_o, data_o, oe_o} = '0;
   always @(posedge clk_sys_i) begin
      // a full period of stable values before the pin rises
      if (!sleep_cmd_i || sleep_pin_o) begin
         {pin_o, data_o, oe_o} <= 24'($urandom);
      end
      sleep_pin_o <= sleep_cmd_i;
   end
endmodule

// ===== verif/pdh_sva.sv
// port assertions for the sleep hold block
`timescale 1ns/1ps
module pdh_sva (
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   input wire logic       sleep_option_i,
   input wire logic       sleep_request_pin_i,
   input wire logic [7:0] array_in_o,
   input wire logic       array_sleep_pin_o,
   input wire logic       logic_run_o,
   input wire logic [7:0] pin_out_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic [7:0] keeper_on_o,
   input wire logic       asleep_o,
   input wire logic       wake_busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sleep_enter_a: assert property (
      (sleep_option_i && sleep_request_pin_i)[*8] |-> asleep_o)
      else $error("no sleep");
   sleep_exit_a: assert property (!sleep_request_pin_i[*8] |-> !asleep_o)
      else $error("no wake");
   out_hold_a: assert property (asleep_o && $past(asleep_o) |->
      $stable(pin_out_o) && $stable(pin_oe_o)) else $error("outputs moved");
   array_freeze_a: assert property (!logic_run_o && !$past(logic_run_o)
      |-> $stable(array_in_o)) else $error("array input moved");
   keeper_run_a: assert property (asleep_o |-> keeper_on_o == 8'hFF
      && !logic_run_o) else $error("keepers or run wrong");
   option_off_a: assert property (!sleep_option_i |-> !asleep_o
      && !wake_busy_o) else $error("slept without option");
   no_feed_a: assert property (sleep_option_i |-> !array_sleep_pin_o)
      else $error("sleep pin fed array");
   wake_bound_a: assert property ($fell(asleep_o) |->
      ##[1:20] (logic_run_o || asleep_o)) else $error("wake too slow");
   cover property ($rose(asleep_o));
   cover property ($fell(wake_busy_o) && logic_run_o);
   cover property (!sleep_option_i && sleep_request_pin_i);
endmodule
bind pdh_core pdh_sva u_sva (.*);
